// file: rtl/flash_port_defines.svh
// register offsets, field positions, reset values and phase sizes of the flash pin port
`ifndef FLASH_PORT_DEFINES_SVH
`define FLASH_PORT_DEFINES_SVH

`define FP_REG_CFG        8'h00
`define FP_REG_TX         8'h04
`define FP_REG_RX         8'h08
`define FP_REG_CMD        8'h0C
`define FP_REG_ADDR       8'h10
`define FP_REG_STAT       8'h14

`define FP_CFG_QE         0
`define FP_CFG_RST_SEL    1
`define FP_CFG_RD         2
`define FP_CFG_TYPE_LSB   4
`define FP_CFG_DUMMY_LSB  8

`define FP_STAT_PAUSED    0
`define FP_STAT_SEL       1
`define FP_STAT_STATE_LSB 2
`define FP_STAT_RXV       8
`define FP_STAT_HWR       9

`define FP_CFG_RESET      32'h0000_0030
`define FP_TX_RESET       8'hFF

`define FP_CMD_BITS       5'h08
`define FP_ADDR_BITS      5'h18
`define FP_BYTE_BITS      5'h08

`endif

// file: rtl/flash_port_pkg.sv
// types shared by the flash pin port
package flash_port_pkg;

    typedef enum logic [2:0] {
        XT_100 = 3'h0,
        XT_110 = 3'h1,
        XT_101 = 3'h2,
        XT_111 = 3'h3,
        XT_112 = 3'h4,
        XT_114 = 3'h5,
        XT_144 = 3'h6,
        XT_044 = 3'h7
    } xfer_type_e;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_CMD   = 5'h02,
        ST_ADDR  = 5'h04,
        ST_DUMMY = 5'h08,
        ST_DATA  = 5'h10
    } port_state_e;

    typedef logic [2:0] lanes_t;

endpackage

// file: rtl/pin_sync.sv
// two-flop synchroniser for pins entering the core clock domain
`timescale 1ns/100ps
module pin_sync #(
    parameter int               WIDTH = 6,
    parameter logic [WIDTH-1:0] INIT  = '0
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // the first stage feeds only the second
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= INIT;
            sync_q <= INIT;
        end else if (ce) begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;
endmodule

// file: rtl/flash_port.sv
// device-side serial flash pin port: fourth-line roles, pause and multi-line transfers
`timescale 1ns/100ps
`include "flash_port_defines.svh"
module flash_port (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        sel_n_pin,
    input  wire logic        sclk_pin,
    input  wire logic [3:0]  io_in,
    output logic      [3:0]  io_out,
    output logic      [3:0]  io_oe_n,
    output logic             io3_pull_up
);
    import flash_port_pkg::*;

    logic [5:0]  sync_pins;
    logic        s_sel_n;
    logic        s_sclk;
    logic [3:0]  s_io;
    logic        sclk_d1_q;
    logic        sel_d1_q;
    logic        io3_d1_q;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        sel_fall;

    logic        cfg_qe_q;
    logic        cfg_rst_sel_q;
    logic        cfg_rd_q;
    xfer_type_e  cfg_type_q;
    logic [4:0]  cfg_dummy_q;
    logic [7:0]  tx_data_q;

    port_state_e state_q;
    xfer_type_e  type_q;
    logic        dir_rd_q;
    logic [4:0]  dummy_q;
    logic [4:0]  edge_cnt_q;
    logic [23:0] in_sh_q;
    logic        paused_q;
    logic [7:0]  cmd_q;
    logic [23:0] addr_q;
    logic [7:0]  rx_data_q;
    logic        rx_valid_q;
    logic        hw_reset_seen_q;
    logic [7:0]  tx_sh_q;
    logic [2:0]  fe_cnt_q;
    logic [3:0]  io_out_q;
    logic [3:0]  io_oe_n_q;
    logic [31:0] rdata_q;
    logic        pull_up_q;

    xfer_type_e  eff_type;
    logic [8:0]  trip;
    lanes_t      cmd_l;
    lanes_t      addr_l;
    lanes_t      data_l;
    lanes_t      cur_l;
    logic [4:0]  phase_bits;
    logic [4:0]  phase_edges;
    logic        phase_last;
    port_state_e next_state;
    logic [23:0] in_next;
    logic        pause_role;
    logic        pin_reset;
    logic        pause_go;
    logic        pause_end;
    logic        drive_ok;
    logic [7:0]  out_val;

    // command, address and data line counts of each transfer type
    function automatic logic [8:0] lane_triple(input xfer_type_e t);
        unique case (t)
            XT_100: lane_triple = {3'h1, 3'h0, 3'h0};
            XT_110: lane_triple = {3'h1, 3'h1, 3'h0};
            XT_101: lane_triple = {3'h1, 3'h0, 3'h1};
            XT_111: lane_triple = {3'h1, 3'h1, 3'h1};
            XT_112: lane_triple = {3'h1, 3'h1, 3'h2};
            XT_114: lane_triple = {3'h1, 3'h1, 3'h4};
            XT_144: lane_triple = {3'h1, 3'h4, 3'h4};
            XT_044: lane_triple = {3'h0, 3'h4, 3'h4};
        endcase
    endfunction

    // lane 0 first; dual adds line one, quad adds lines two and three
    function automatic logic [23:0] shift_in(input logic [23:0] sh, input logic [3:0] io,
                                             input lanes_t l);
        unique case (l)
            3'h2:    shift_in = {sh[21:0], io[1:0]};
            3'h4:    shift_in = {sh[19:0], io};
            default: shift_in = {sh[22:0], io[0]};
        endcase
    endfunction

    function automatic logic [3:0] oe_mask(input lanes_t l);
        unique case (l)
            3'h2:    oe_mask = 4'hC;
            3'h4:    oe_mask = 4'h0;
            default: oe_mask = 4'hD;
        endcase
    endfunction

    pin_sync #(
        .WIDTH (6),
        .INIT  (6'h2F)
    ) u_sync (
        .clk    (core_clk),
        .resetn (resetn),
        .ce     (ce),
        .d      ({sel_n_pin, sclk_pin, io_in}),
        .q      (sync_pins)
    );

    assign s_sel_n = sync_pins[5];
    assign s_sclk  = sync_pins[4];
    assign s_io    = sync_pins[3:0];

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sclk_d1_q <= 1'b0;
            sel_d1_q  <= 1'b1;
            io3_d1_q  <= 1'b1;
        end else if (ce) begin
            sclk_d1_q <= s_sclk;
            sel_d1_q  <= s_sel_n;
            io3_d1_q  <= s_io[3];
        end
    end

    assign sclk_rise = s_sclk & ~sclk_d1_q;
    assign sclk_fall = ~s_sclk & sclk_d1_q;
    assign sel_fall  = ~s_sel_n & sel_d1_q;

    // fourth line roles; with quad enabled the line is data only
    assign pause_role = ~cfg_qe_q & ~cfg_rst_sel_q;
    assign pin_reset  = ~cfg_qe_q & cfg_rst_sel_q & ~s_io[3];
    assign pause_go   = pause_role & ~s_sel_n & ~s_sclk & io3_d1_q & ~s_io[3];
    assign pause_end  = ~s_sclk & ~io3_d1_q & s_io[3];

    // quad types fall back to single lines unless quad lines are enabled
    assign eff_type = (!cfg_qe_q && cfg_type_q inside {XT_114, XT_144, XT_044}) ?
                      XT_111 : cfg_type_q;

    assign trip   = lane_triple(type_q);
    assign cmd_l  = trip[8:6];
    assign addr_l = trip[5:3];
    assign data_l = trip[2:0];

    always_comb begin
        cur_l      = data_l;
        phase_bits = `FP_BYTE_BITS;
        next_state = ST_DATA;
        unique case (state_q)
            ST_CMD: begin
                cur_l      = cmd_l;
                phase_bits = `FP_CMD_BITS;
                if (addr_l != 3'h0) begin
                    next_state = ST_ADDR;
                end else if (data_l == 3'h0) begin
                    next_state = ST_IDLE;
                end
            end
            ST_ADDR: begin
                cur_l      = addr_l;
                phase_bits = `FP_ADDR_BITS;
                if (data_l == 3'h0) begin
                    next_state = ST_IDLE;
                end else if (dummy_q != 5'h00) begin
                    next_state = ST_DUMMY;
                end
            end
            ST_IDLE, ST_DUMMY, ST_DATA: begin
                next_state = ST_DATA;
            end
        endcase
        if (state_q == ST_DUMMY) begin
            phase_edges = dummy_q;
        end else if (cur_l == 3'h4) begin
            phase_edges = phase_bits >> 2;
        end else if (cur_l == 3'h2) begin
            phase_edges = phase_bits >> 1;
        end else begin
            phase_edges = phase_bits;
        end
    end

    assign phase_last = (edge_cnt_q == phase_edges - 5'h01);
    assign in_next    = shift_in(in_sh_q, s_io, cur_l);

    // pause: counters hold, nothing restarts
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            paused_q <= 1'b0;
        end else if (ce) begin
            if (pin_reset || cfg_qe_q || s_sel_n) begin
                paused_q <= 1'b0;
            end else if (!paused_q && pause_go) begin
                paused_q <= 1'b1;
            end else if (paused_q && pause_end) begin
                paused_q <= 1'b0;
            end
        end
    end

    // frame sequencer, advanced on rising serial clock only
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_q    <= ST_IDLE;
            type_q     <= XT_111;
            dir_rd_q   <= 1'b0;
            dummy_q    <= 5'h00;
            edge_cnt_q <= 5'h00;
            in_sh_q    <= 24'h00_0000;
        end else if (ce) begin
            if (pin_reset || s_sel_n) begin
                state_q    <= ST_IDLE;
                edge_cnt_q <= 5'h00;
            end else if (sel_fall) begin
                type_q     <= eff_type;
                dir_rd_q   <= cfg_rd_q;
                dummy_q    <= cfg_dummy_q;
                edge_cnt_q <= 5'h00;
                state_q    <= (eff_type == XT_044) ? ST_ADDR : ST_CMD;
            end else if (sclk_rise && !paused_q && state_q != ST_IDLE) begin
                in_sh_q <= in_next;
                if (phase_last) begin
                    edge_cnt_q <= 5'h00;
                    state_q    <= next_state;
                end else begin
                    edge_cnt_q <= edge_cnt_q + 5'h01;
                end
            end
        end
    end

    // captured fields; a received data byte wins over a same-cycle valid-flag clear
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cmd_q           <= 8'h00;
            addr_q          <= 24'h00_0000;
            rx_data_q       <= 8'h00;
            rx_valid_q      <= 1'b0;
            hw_reset_seen_q <= 1'b0;
        end else if (ce) begin
            if (pin_reset) begin
                cmd_q  <= 8'h00;
                addr_q <= 24'h00_0000;
            end else if (sclk_rise && !paused_q && !s_sel_n && phase_last) begin
                if (state_q == ST_CMD) begin
                    cmd_q <= in_next[7:0];
                end
                if (state_q == ST_ADDR) begin
                    addr_q <= in_next;
                end
            end
            if (sclk_rise && !paused_q && !s_sel_n && phase_last && !pin_reset &&
                state_q == ST_DATA && !dir_rd_q) begin
                rx_data_q  <= in_next[7:0];
                rx_valid_q <= 1'b1;
            end else if (reg_wr && reg_addr == `FP_REG_STAT && reg_wdata[`FP_STAT_RXV]) begin
                rx_valid_q <= 1'b0;
            end
            if (pin_reset) begin
                hw_reset_seen_q <= 1'b1;
            end else if (reg_wr && reg_addr == `FP_REG_STAT && reg_wdata[`FP_STAT_HWR]) begin
                hw_reset_seen_q <= 1'b0;
            end
        end
    end

    // read data leaves on the falling serial clock, top bits first
    assign drive_ok = (state_q == ST_DATA) && dir_rd_q && !paused_q && !s_sel_n && !pin_reset;
    assign out_val  = (fe_cnt_q == 3'h0) ? tx_data_q : tx_sh_q;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            io_out_q  <= 4'h0;
            io_oe_n_q <= 4'hF;
            tx_sh_q   <= 8'h00;
            fe_cnt_q  <= 3'h0;
        end else if (ce) begin
            io_oe_n_q <= drive_ok ? oe_mask(data_l) : 4'hF;
            if (state_q != ST_DATA) begin
                fe_cnt_q <= 3'h0;
            end else if (drive_ok && sclk_fall) begin
                unique case (data_l)
                    3'h4: begin
                        io_out_q <= out_val[7:4];
                        tx_sh_q  <= {out_val[3:0], 4'h0};
                        fe_cnt_q <= (fe_cnt_q == 3'h1) ? 3'h0 : fe_cnt_q + 3'h1;
                    end
                    3'h2: begin
                        io_out_q <= {2'h0, out_val[7:6]};
                        tx_sh_q  <= {out_val[5:0], 2'h0};
                        fe_cnt_q <= (fe_cnt_q == 3'h3) ? 3'h0 : fe_cnt_q + 3'h1;
                    end
                    default: begin
                        io_out_q <= {2'h0, out_val[7], 1'b0};
                        tx_sh_q  <= {out_val[6:0], 1'b0};
                        fe_cnt_q <= fe_cnt_q + 3'h1;
                    end
                endcase
            end
        end
    end

    // always-on pull-up so an unused fourth line reads released
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pull_up_q <= 1'b1;
        end else if (ce) begin
            pull_up_q <= 1'b1;
        end
    end

    // register writes; the frame latches its settings at select fall
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_qe_q      <= 1'(`FP_CFG_RESET >> `FP_CFG_QE);
            cfg_rst_sel_q <= 1'(`FP_CFG_RESET >> `FP_CFG_RST_SEL);
            cfg_rd_q      <= 1'(`FP_CFG_RESET >> `FP_CFG_RD);
            cfg_type_q    <= xfer_type_e'(3'(`FP_CFG_RESET >> `FP_CFG_TYPE_LSB));
            cfg_dummy_q   <= 5'h00;
            tx_data_q     <= `FP_TX_RESET;
        end else if (ce && reg_wr) begin
            if (reg_addr == `FP_REG_CFG) begin
                cfg_qe_q      <= reg_wdata[`FP_CFG_QE];
                cfg_rst_sel_q <= reg_wdata[`FP_CFG_RST_SEL];
                cfg_rd_q      <= reg_wdata[`FP_CFG_RD];
                cfg_type_q    <= xfer_type_e'(reg_wdata[`FP_CFG_TYPE_LSB +: 3]);
                cfg_dummy_q   <= reg_wdata[`FP_CFG_DUMMY_LSB +: 5];
            end
            if (reg_addr == `FP_REG_TX) begin
                tx_data_q <= reg_wdata[7:0];
            end
        end
    end

    // read data stands one cycle; unmapped offsets read zero
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (ce) begin
            rdata_q <= 32'h0000_0000;
            if (reg_rd) begin
                unique case (reg_addr)
                    `FP_REG_CFG:  rdata_q <= {19'h0, cfg_dummy_q, 1'b0, cfg_type_q, 1'b0,
                                              cfg_rd_q, cfg_rst_sel_q, cfg_qe_q};
                    `FP_REG_TX:   rdata_q <= {24'h0, tx_data_q};
                    `FP_REG_RX:   rdata_q <= {24'h0, rx_data_q};
                    `FP_REG_CMD:  rdata_q <= {24'h0, cmd_q};
                    `FP_REG_ADDR: rdata_q <= {8'h0, addr_q};
                    `FP_REG_STAT: rdata_q <= {22'h0, hw_reset_seen_q, rx_valid_q, 1'b0,
                                              state_q, ~s_sel_n, paused_q};
                    default:      rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign reg_rdata   = rdata_q;
    assign io_out      = io_out_q;
    assign io_oe_n     = io_oe_n_q;
    assign io3_pull_up = pull_up_q;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    a_qe_no_pause: assert property (ce && cfg_qe_q |=> !paused_q)
        else $error("pause held while quad lines enabled");
    a_pause_enter: assert property (ce && !paused_q && pause_go && !pin_reset |=> paused_q)
        else $error("pause not entered on pause line fall");
    a_pause_exit: assert property (ce && paused_q && pause_end && !s_sel_n |=> !paused_q)
        else $error("pause not left on pause line rise");
    a_desel_no_pause: assert property (ce && s_sel_n |=> !paused_q)
        else $error("pause while deselected");
    a_pause_freeze: assert property (ce && paused_q && !s_sel_n && !pin_reset
        |=> $stable(edge_cnt_q) && $stable(state_q) && $stable(fe_cnt_q))
        else $error("counts moved during pause");
    a_pause_float: assert property ($past(ce && paused_q) |-> io_oe_n_q == 4'hF)
        else $error("outputs driven during pause");
    a_reset_idle: assert property (ce && pin_reset |=> state_q == ST_IDLE ##1 io_oe_n_q == 4'hF)
        else $error("reset line did not idle the port");
    a_sel_ends: assert property (ce && s_sel_n |=> state_q == ST_IDLE)
        else $error("frame survived select rise");
    a_lane_masks: assert property (io_oe_n_q != 4'hF |-> io_oe_n_q inside {4'hD, 4'hC, 4'h0})
        else $error("illegal output lane pattern");
    a_single_out: assert property (io_oe_n_q == 4'hD |-> type_q inside {XT_101, XT_111})
        else $error("single line read on wrong type");
    a_quad_out: assert property (io_oe_n_q == 4'h0 |-> type_q inside {XT_114, XT_144, XT_044})
        else $error("four lines driven outside quad types");
    a_rise_count: assert property (ce && sclk_rise && !paused_q && !s_sel_n && !pin_reset
        && state_q == ST_CMD && !phase_last |=> edge_cnt_q == $past(edge_cnt_q) + 5'h01)
        else $error("rising edge not counted");
endmodule

// file: verification/flash_host_model.sv
// host-side serial flash controller model driving select, clock and lines
`timescale 1ns/100ps
module flash_host_model (
    output logic            sel_n,
    output logic            sclk,
    output logic      [3:0] drv,
    output logic      [3:0] en,
    input  wire logic [3:0] io
);
    localparam realtime HALF = 62.5;

    initial begin
        sel_n = 1'b1;
        sclk  = 1'b0;
        drv   = 4'h0;
        en    = 4'h0;
    end

    task automatic start();
        #1 sel_n = 1'b0;
        #(HALF);
    endtask

    // data only changes while sclk is low, so every rise sees settled lanes
    task automatic send(input int nl, input int nb, input logic [31:0] v);
        en = 4'((1 << nl) - 1);
        for (int i = nb; i > 0; i -= nl) begin
            drv = 4'(v >> (i - nl)) & en;
            #(HALF) sclk = 1'b1;
            #(HALF) sclk = 1'b0;
        end
    endtask

    task automatic recv(input int nl, input int nb, output logic [31:0] v);
        en = 4'h0;
        v  = 32'h0;
        for (int i = nb; i > 0; i -= nl) begin
            #(HALF) sclk = 1'b1;
            v = (v << nl) | ((nl == 1) ? 32'(io[1]) : 32'(io & 4'((1 << nl) - 1)));
            #(HALF) sclk = 1'b0;
        end
    endtask

    // pause line moves only with sclk low; callers keep it unused while quad is on
    task automatic hold(input logic on);
        #1 drv[3] = ~on;
        en[3]  = 1'b1;
        #(HALF);
        en[3] = on;
    endtask

    task automatic pulse(input int n);
        repeat (n) begin
            #(HALF) sclk = 1'b1;
            #(HALF) sclk = 1'b0;
        end
    endtask

    task automatic stop();
        en = 4'h0;
        #(HALF) sel_n = 1'b1;
        #(4 * HALF);
    endtask
endmodule

// file: verification/multi_io_flash_port_pin_modes_test.sv
// self-checking bench for the flash pin port: transfer types, pause and reset roles
`timescale 1ns/100ps
`include "flash_port_defines.svh"
module multi_io_flash_port_pin_modes_test;
    // line counts per type code: command, address, data
    localparam logic [11:0] LANES [8] = '{12'h100, 12'h110, 12'h101, 12'h111,
                                          12'h112, 12'h114, 12'h144, 12'h044};
    logic        core_clk  = 1'b0;
    logic        resetn    = 1'b0;
    logic        ce        = 1'b1;
    logic [7:0]  reg_addr  = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [31:0] reg_rdata;
    logic        sel_n;
    logic        sclk;
    logic [3:0]  h_drv;
    logic [3:0]  h_en;
    logic [3:0]  io_in;
    logic [3:0]  io_out;
    logic [3:0]  io_oe_n;
    logic        io3_pull_up;
    logic [3:0]  junk      = 4'h5;
    int          err_total  = 0;
    int          n_compared = 0;

    always #2.5 core_clk = ~core_clk;
    // released lines other than the pulled-up fourth show a changing pattern, never a stale value
    always @(posedge core_clk) junk <= ~junk;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            io_in[i] = !io_oe_n[i] ? io_out[i] : h_en[i] ? h_drv[i] :
                       (i == 3 && io3_pull_up) ? 1'b1 : junk[i];
        end
    end

    flash_port u_dut (
        .core_clk    (core_clk),
        .resetn      (resetn),
        .ce          (ce),
        .reg_addr    (reg_addr),
        .reg_wdata   (reg_wdata),
        .reg_wr      (reg_wr),
        .reg_rd      (reg_rd),
        .reg_rdata   (reg_rdata),
        .sel_n_pin   (sel_n),
        .sclk_pin    (sclk),
        .io_in       (io_in),
        .io_out      (io_out),
        .io_oe_n     (io_oe_n),
        .io3_pull_up (io3_pull_up)
    );

    flash_host_model u_host (.sel_n(sel_n), .sclk(sclk), .drv(h_drv), .en(h_en), .io(io_in));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_expect(input string what, input logic [7:0] a,
                              input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] g;
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 g = reg_rdata;
        check(what, exp, g & mask);
    endtask

    task automatic pause_chk();
        repeat (6) @(posedge core_clk);
        u_host.hold(1'b1);
        repeat (8) @(posedge core_clk);
        reg_expect("paused", `FP_REG_STAT, 32'h1, 32'h1);
        check("lines float", 32'hF, 32'(io_oe_n));
        u_host.pulse(3);
        u_host.hold(1'b0);
        repeat (8) @(posedge core_clk);
    endtask

    task automatic xfer(input logic [2:0] t, input logic rd, input bit mid_pause);
        logic [11:0] ln;
        logic [7:0]  c;
        logic [23:0] a;
        logic [7:0]  d;
        logic [31:0] g;
        logic [31:0] g2;
        logic [4:0]  dm;
        ln = LANES[t];
        c  = 8'($urandom);
        a  = 24'($urandom);
        d  = 8'($urandom);
        dm = 5'($urandom % 4);
        reg_write(`FP_REG_CFG, 32'({dm, 1'b0, t, 1'b0, rd, 1'b0, t > 3'h4}));
        reg_write(`FP_REG_TX, 32'(d));
        u_host.start();
        if (ln[11:8] != 0) u_host.send(1, 8, 32'(c));
        if (ln[7:4] != 0) u_host.send(int'(ln[7:4]), 24, 32'(a));
        if (ln[7:4] != 0 && ln[3:0] != 0) u_host.pulse(int'(dm));
        if (ln[3:0] != 0 && rd) begin
            u_host.recv(int'(ln[3:0]), 4, g);
            if (mid_pause) pause_chk();
            u_host.recv(int'(ln[3:0]), 4, g2);
            check("read data", 32'(d), (g << 4) | g2);
        end else if (ln[3:0] != 0) begin
            u_host.send(int'(ln[3:0]), 8, 32'(d));
            u_host.stop();
            reg_expect("rx", `FP_REG_RX, 32'hFF, 32'(d));
        end
        u_host.stop();
        if (ln[11:8] != 0) reg_expect("cmd", `FP_REG_CMD, 32'hFF, 32'(c));
        if (ln[7:4] != 0) reg_expect("addr", `FP_REG_ADDR, 32'hFFFFFF, 32'(a));
    endtask

    task automatic wrap_up();
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #400_000;
        err_total++;
        $display("BAD watchdog expected finish seen timeout");
        wrap_up();
    end

    initial begin
        void'($urandom(32'hCA97));
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge core_clk);
        reg_expect("cfg", `FP_REG_CFG, 32'hFFFFFFFF, `FP_CFG_RESET);
        reg_expect("tx", `FP_REG_TX, 32'hFFFFFFFF, 32'(`FP_TX_RESET));
        reg_expect("stat", `FP_REG_STAT, 32'hFFFFFFFF, 32'h4);
        reg_expect("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
        check("pull up", 32'h1, 32'(io3_pull_up));
        check("idle float", 32'hF, 32'(io_oe_n));
        $display("test reset values done");
        u_host.hold(1'b1);
        repeat (8) @(posedge core_clk);
        reg_expect("no pause", `FP_REG_STAT, 32'h1, 32'h0);
        u_host.hold(1'b0);
        $display("test deselected pause done");
        for (int t = 0; t < 8; t++) begin
            xfer(3'(t), 1'b0, 1'b0);
            xfer(3'(t), 1'b1, 1'b0);
        end
        repeat (6) xfer(3'($urandom), 1'($urandom), 1'b0);
        $display("test transfer types done");
        // quad type with quad lines off must run as plain single-line transfer
        reg_write(`FP_REG_CFG, 32'h50);
        u_host.start();
        u_host.send(1, 8, 32'hC3);
        u_host.send(1, 24, 32'h00A5A5);
        u_host.send(1, 8, 32'h96);
        u_host.stop();
        reg_expect("quad off rx", `FP_REG_RX, 32'hFF, 32'h96);
        reg_expect("rx valid", `FP_REG_STAT, 32'h100, 32'h100);
        $display("test quad fallback done");
        xfer(3'h3, 1'b1, 1'b1);
        $display("test pause done");
        reg_write(`FP_REG_CFG, 32'h32);
        u_host.start();
        u_host.send(1, 8, 32'h5A);
        u_host.send(1, 12, 32'h123);
        u_host.hold(1'b1);
        repeat (8) @(posedge core_clk);
        u_host.hold(1'b0);
        u_host.stop();
        reg_expect("hw reset", `FP_REG_STAT, 32'h27C, 32'h204);
        reg_expect("cmd cleared", `FP_REG_CMD, 32'hFF, 32'h0);
        reg_expect("cfg kept", `FP_REG_CFG, 32'h1FFF, 32'h32);
        reg_write(`FP_REG_STAT, 32'h300);
        reg_expect("flags cleared", `FP_REG_STAT, 32'h300, 32'h0);
        $display("test reset role done");
        // a write while the clock enable is low must not land
        @(posedge core_clk);
        ce <= 1'b0;
        reg_write(`FP_REG_CFG, 32'h0);
        ce <= 1'b1;
        reg_expect("frozen cfg", `FP_REG_CFG, 32'h1FFF, 32'h32);
        $display("test clock enable done");
        wrap_up();
    end
endmodule
